// *** rtl/rx_channel_config_latches.sv ***
// Serial-loaded configuration latches with power control outputs and register readback.
// Assumes the controller holds serial clock still while the load strobe is high.
`timescale 1ns/1ps

module rx_channel_config_latches (
    input  wire logic                         clock,
    input  wire logic                         rst,
    input  wire logic                         serial_clock,
    input  wire logic                         serial_data,
    input  wire logic                         load_strobe,
    output rx_config_pkg::power_ctrl_t        power_ctrl,
    output logic [4:0][31:0]                  channel_lo_setup,
    output logic [4:0]                        test_sel,
    output logic                              temp_to_analog_test_pin,
    output logic                              serial_data_out
);

    // ==========================================================
    // Link domain: reset synchroniser, input shifter, readback shifter
    logic        link_rst_meta;
    logic        link_rst;
    logic [31:0] shift_word;
    logic [31:0] next_shift_word;
    logic        rb_tog_meta;
    logic        rb_tog_sync;
    logic        rb_tog_seen;
    logic        next_rb_tog_seen;
    logic [31:0] rb_shift;
    logic [31:0] next_rb_shift;

    // ==========================================================
    // Main domain state
    logic        le_meta;
    logic        le_sync;
    logic        le_prev;
    logic [31:0] power_control_latch;
    logic [31:0] next_power_control_latch;
    logic [4:0][31:0] setup_slots;
    logic [4:0][31:0] next_setup_slots;
    logic [31:0] test_select_latch;
    logic [31:0] next_test_select_latch;
    logic [31:0] spare_latch;
    logic [31:0] next_spare_latch;
    logic        rb_tog;
    logic        next_rb_tog;
    logic [31:0] rb_word;
    logic [31:0] next_rb_word;
    rx_config_pkg::power_ctrl_t next_power_ctrl;
    logic        next_temp_to_analog_test_pin;
    logic        load_edge;
    logic [1:0]  latch_sel;
    logic [2:0]  chan_sel;

    function automatic logic [31:0] readback_pick(
        input logic [4:0]       code,
        input logic [31:0]      pwr,
        input logic [4:0][31:0] setup,
        input logic [31:0]      tst
    );
        logic [31:0] r;
        r = rx_config_pkg::LATCH_RESET;
        case (code)
            rx_config_pkg::TEST_RB_POWER: r = pwr;
            rx_config_pkg::TEST_RB_CH1:   r = setup[0];
            rx_config_pkg::TEST_RB_CH2:   r = setup[1];
            rx_config_pkg::TEST_RB_CH3:   r = setup[2];
            rx_config_pkg::TEST_RB_CH4:   r = setup[3];
            rx_config_pkg::TEST_RB_LO:    r = setup[4];
            rx_config_pkg::TEST_RB_TEST:  r = tst;
            default:                      r = rx_config_pkg::LATCH_RESET;
        endcase
        return r;
    endfunction

    // ==========================================================
    // Link domain logic
    always_comb begin
        next_shift_word  = {shift_word[30:0], serial_data};
        next_rb_tog_seen = rb_tog_sync;
        if (rb_tog_sync != rb_tog_seen) begin
            next_rb_shift = rb_word;
        end else begin
            next_rb_shift = {rb_shift[30:0], 1'b0};
        end
    end

    always_ff @(posedge serial_clock) begin
        link_rst_meta <= rst;
        link_rst      <= link_rst_meta;
        rb_tog_meta   <= rb_tog;
        rb_tog_sync   <= rb_tog_meta;
        if (link_rst) begin
            shift_word      <= rx_config_pkg::LATCH_RESET;
            rb_tog_seen     <= 1'b0;
            rb_shift        <= rx_config_pkg::LATCH_RESET;
            serial_data_out <= 1'b0;
        end else begin
            shift_word      <= next_shift_word;
            rb_tog_seen     <= next_rb_tog_seen;
            rb_shift        <= next_rb_shift;
            serial_data_out <= next_rb_shift[31];
        end
    end

    // ==========================================================
    // Main domain: strobe edge and latch decode
    assign load_edge = le_sync & ~le_prev;
    assign latch_sel = shift_word[1:0];
    assign chan_sel  = shift_word[rx_config_pkg::CHAN_SEL_HI:rx_config_pkg::CHAN_SEL_LO];

    always_comb begin
        next_power_control_latch = power_control_latch;
        next_setup_slots          = setup_slots;
        next_test_select_latch    = test_select_latch;
        next_spare_latch          = spare_latch;
        next_rb_tog               = rb_tog;
        if (load_edge) begin
            // Word is stable: serial clock is held while the strobe is high
            next_rb_tog = ~rb_tog;
            case (latch_sel)
                rx_config_pkg::SEL_POWER: begin
                    next_power_control_latch = shift_word;
                end
                rx_config_pkg::SEL_SETUP: begin
                    if (chan_sel >= rx_config_pkg::CHAN_SEL_CH1 &&
                        chan_sel <= rx_config_pkg::CHAN_SEL_LO_PATH) begin
                        next_setup_slots[3'(chan_sel - rx_config_pkg::CHAN_SEL_CH1)] = shift_word;
                    end
                end
                rx_config_pkg::SEL_TEST: begin
                    next_test_select_latch = shift_word;
                end
                rx_config_pkg::SEL_SPARE: begin
                    next_spare_latch = shift_word;
                end
                default: begin
                    next_spare_latch = spare_latch;
                end
            endcase
        end
        next_rb_word = readback_pick(
            next_test_select_latch[rx_config_pkg::TEST_SEL_HI:rx_config_pkg::TEST_SEL_LO],
            next_power_control_latch, next_setup_slots, next_test_select_latch);
        next_power_ctrl.rx_power_on = next_power_control_latch[rx_config_pkg::PUP_CH1_BIT +: 4];
        next_power_ctrl.local_osc_power_on = next_power_control_latch[rx_config_pkg::LOCAL_OSC_POWER_ON_BIT];
        next_power_ctrl.lo_pin_bias   = next_power_control_latch[rx_config_pkg::LO_PIN_BIAS_BIT];
        next_power_ctrl.dout_low_volt = next_power_control_latch[rx_config_pkg::DOUT_VSEL_BIT];
        next_temp_to_analog_test_pin  =
            next_test_select_latch[rx_config_pkg::TEST_SEL_HI:rx_config_pkg::TEST_SEL_LO]
            == rx_config_pkg::TEST_TEMP;
    end

    always_ff @(posedge clock) begin
        le_meta <= load_strobe;
        le_sync <= le_meta;
        if (rst) begin
            le_prev                 <= 1'b0;
            power_control_latch     <= rx_config_pkg::LATCH_RESET;
            setup_slots             <= {rx_config_pkg::SETUP_SLOTS{rx_config_pkg::LATCH_RESET}};
            test_select_latch       <= rx_config_pkg::LATCH_RESET;
            spare_latch             <= rx_config_pkg::LATCH_RESET;
            rb_tog                  <= 1'b0;
            rb_word                 <= rx_config_pkg::LATCH_RESET;
            power_ctrl              <= '0;
            channel_lo_setup        <= {rx_config_pkg::SETUP_SLOTS{rx_config_pkg::LATCH_RESET}};
            test_sel                <= 5'h00;
            temp_to_analog_test_pin <= 1'b0;
        end else begin
            le_prev                 <= le_sync;
            power_control_latch     <= next_power_control_latch;
            setup_slots             <= next_setup_slots;
            test_select_latch       <= next_test_select_latch;
            spare_latch             <= next_spare_latch;
            rb_tog                  <= next_rb_tog;
            rb_word                 <= next_rb_word;
            power_ctrl              <= next_power_ctrl;
            channel_lo_setup        <= next_setup_slots;
            test_sel                <= next_test_select_latch[rx_config_pkg::TEST_SEL_HI:rx_config_pkg::TEST_SEL_LO];
            temp_to_analog_test_pin <= next_temp_to_analog_test_pin;
        end
    end

endmodule

// *** rtl/rx_config_pkg.sv ***
// Constants, field positions and carrier types for the receiver configuration latches.
// Assumes a serial controller that shifts 32-bit words and pulses a load strobe.

package rx_config_pkg;

    // ==========================================================
    // Word and latch select
    localparam int        WORD_W        = 32;
    localparam logic [1:0] SEL_POWER    = 2'h0;
    localparam logic [1:0] SEL_SETUP    = 2'h1;
    localparam logic [1:0] SEL_TEST     = 2'h2;
    localparam logic [1:0] SEL_SPARE    = 2'h3;

    // ==========================================================
    // Power control field positions
    localparam int DOUT_VSEL_BIT   = 8;
    localparam int LO_PIN_BIAS_BIT = 9;
    localparam int LOCAL_OSC_POWER_ON_BIT      = 10;
    localparam int PUP_CH1_BIT     = 11;

    // ==========================================================
    // Setup latch channel select, slots 0..3 channels, 4 LO
    localparam int         CHAN_SEL_HI = 31;
    localparam int         CHAN_SEL_LO = 29;
    localparam logic [2:0] CHAN_SEL_CH1 = 3'h1;
    localparam logic [2:0] CHAN_SEL_LO_PATH = 3'h5;
    localparam int         SETUP_SLOTS = 5;

    // ==========================================================
    // Test select field and codes
    localparam int         TEST_SEL_HI   = 14;
    localparam int         TEST_SEL_LO   = 10;
    localparam logic [4:0] TEST_TEMP     = 5'h01;
    localparam logic [4:0] TEST_RB_POWER = 5'h02;
    localparam logic [4:0] TEST_RB_CH1   = 5'h03;
    localparam logic [4:0] TEST_RB_CH2   = 5'h04;
    localparam logic [4:0] TEST_RB_CH3   = 5'h05;
    localparam logic [4:0] TEST_RB_CH4   = 5'h06;
    localparam logic [4:0] TEST_RB_LO    = 5'h07;
    localparam logic [4:0] TEST_RB_TEST  = 5'h08;

    // ==========================================================
    // Reset values
    localparam logic [31:0] LATCH_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [3:0] rx_power_on;
        logic       local_osc_power_on;
        logic       lo_pin_bias;
        logic       dout_low_volt;
    } power_ctrl_t;

endpackage

// *** tb/rx_config_monitor.sv ***
// Port checker for the configuration latch block.
// Bound to the top module; shadows the serial word itself.
`timescale 1ns/1ps
module rx_config_monitor (
    input wire logic                       clock,
    input wire logic                       rst,
    input wire logic                       serial_clock,
    input wire logic                       serial_data,
    input wire logic                       load_strobe,
    input wire rx_config_pkg::power_ctrl_t power_ctrl,
    input wire logic [4:0][31:0]           channel_lo_setup,
    input wire logic [4:0]                 test_sel,
    input wire logic                       temp_to_analog_test_pin,
    input wire logic                       serial_data_out
);
    logic [31:0] sh;
    always_ff @(posedge serial_clock) begin
        sh <= {sh[30:0], serial_data};
    end
    default clocking dcb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================================
    // Properties
    reset_clear_a: assert property (disable iff (1'b0) rst |=>
        power_ctrl == '0 && test_sel == 5'h00 && channel_lo_setup == '0) else $error("outputs not cleared");
    hold_idle_a: assert property ((!load_strobe)[*5] |->
        $stable(power_ctrl) && $stable(test_sel) && $stable(channel_lo_setup)) else $error("latch moved");
    power_cause_a: assert property ($changed(power_ctrl) |-> $past(load_strobe, 2))
        else $error("power change without strobe");
    rx2_power_a: assert property (($rose(load_strobe) && sh[1:0] == 2'h0) |->
        ##4 power_ctrl.rx_power_on[1] == sh[12]) else $error("rx2 power wrong");
    rx3_power_a: assert property (($rose(load_strobe) && sh[1:0] == 2'h0) |->
        ##4 power_ctrl.rx_power_on[2] == sh[13]) else $error("rx3 power wrong");
    rx4_power_a: assert property (($rose(load_strobe) && sh[1:0] == 2'h0) |->
        ##4 power_ctrl.rx_power_on[3] == sh[14]) else $error("rx4 power wrong");
    setup_store_a: assert property (($rose(load_strobe) && sh[1:0] == 2'h1 && sh[31:29] == 3'h2) |->
        ##4 channel_lo_setup[1] == sh) else $error("setup slot wrong");
    test_store_a: assert property (($rose(load_strobe) && sh[1:0] == 2'h2) |->
        ##4 test_sel == sh[14:10]) else $error("test select wrong");
    temp_route_a: assert property ((test_sel == 5'h01)[*2] |-> temp_to_analog_test_pin)
        else $error("temp route missing");
    spare_quiet_a: assert property (($rose(load_strobe) && sh[1:0] == 2'h3) |->
        ##1 ($stable(power_ctrl) && $stable(test_sel))[*5]) else $error("spare write leaked");
endmodule
bind rx_channel_config_latches rx_config_monitor u_mon (.clock, .rst, .serial_clock, .serial_data,
    .load_strobe, .power_ctrl, .channel_lo_setup, .test_sel, .temp_to_analog_test_pin, .serial_data_out);

// *** tb/rx_ctrl_model.sv ***
// Serial controller model: shifts words, strobes loads, samples readback.
// Serial clock runs only inside frames, 32 ns period.
`timescale 1ns/1ps
module rx_ctrl_model (
    output logic      serial_clock,
    output logic      serial_data,
    output logic      load_strobe,
    input  wire logic serial_data_out
);
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    task automatic shift(input logic [33:0] w, input int n, output logic [31:0] rb);
        for (int i = n - 1; i >= 0; i--) begin
            serial_data = w[i];
            #16 serial_clock = 1'b1;
            #8 rb = {rb[30:0], serial_data_out};
            #8 serial_clock = 1'b0;
        end
        serial_data = ~serial_data;
    endtask
    // Clock held still 416 ns around the strobe
    task automatic load();
        #16 load_strobe = 1'b1;
        #200 load_strobe = 1'b0;
        #200;
    endtask
endmodule

// *** tb/tb_rx_channel_config_latches.sv ***
// Self-checking bench for the configuration latch block.
// Drives the controller model and compares against a reference.
`timescale 1ns/1ps
module tb_rx_channel_config_latches;
    logic clock = 1'b0, rst, sck, sdi, le, sdo, temp;
    rx_config_pkg::power_ctrl_t pc;
    logic [4:0][31:0] setup, e_setup;
    logic [4:0]       tsel;
    logic [31:0]      e_pwr, e_tst, rb, x;
    int num_errors = 0, n_checks = 0, cyc = 0;
    typedef struct packed { logic [31:0] word; logic [6:0] pwr; } row_t;
    row_t rows [13] = '{{32'h00000003, 7'h00}, {32'h00020406, 7'h00}, {32'h20001499, 7'h00},
        {32'h40001499, 7'h00}, {32'h60001499, 7'h00}, {32'h80001499, 7'h00}, {32'ha0000019, 7'h00},
        {32'h80007ca0, 7'h7c}, {32'hc0001499, 7'h7c}, {32'h00001000, 7'h10}, {32'h00002000, 7'h20},
        {32'h00004000, 7'h40}, {32'h00000003, 7'h40}};
    rx_channel_config_latches u_dut (.clock(clock), .rst(rst), .serial_clock(sck), .serial_data(sdi),
        .load_strobe(le), .power_ctrl(pc), .channel_lo_setup(setup), .test_sel(tsel),
        .temp_to_analog_test_pin(temp), .serial_data_out(sdo));
    rx_ctrl_model u_ctrl (.serial_clock(sck), .serial_data(sdi), .load_strobe(le), .serial_data_out(sdo));
    always #25 clock = ~clock;
    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] w);
        u_ctrl.shift({2'h0, w}, 32, rb);
        u_ctrl.load();
        case (w[1:0])
            2'h0: e_pwr = w;
            2'h1: if (w[31:29] >= 3'h1 && w[31:29] <= 3'h5) e_setup[w[31:29] - 3'h1] = w;
            2'h2: e_tst = w;
            default: ;
        endcase
    endtask
    task automatic chk();
        cmp({25'h0, pc}, {25'h0, e_pwr[14:8]});
        for (int s = 0; s < 5; s++) cmp(setup[s], e_setup[s]);
        cmp({27'h0, tsel}, {27'h0, e_tst[14:10]});
        cmp({31'h0, temp}, {31'h0, e_tst[14:10] == 5'h01});
    endtask
    initial begin
        rst = 1'b1;
        e_pwr = '0;
        e_tst = '0;
        e_setup = '0;
        u_ctrl.shift(34'h0, 4, rb);
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        repeat (2) @(posedge clock);
        chk();
        // Startup sequence, refused slot, power bits, spare
        for (int i = 0; i < 13; i++) begin
            wr(rows[i].word);
            cmp({25'h0, pc}, {25'h0, rows[i].pwr});
            chk();
        end
        $display("test rows done");
        // Readback of codes 2 to 9, shifting without a load
        for (int c = 2; c < 10; c++) begin
            wr({17'h0, c[4:0], 10'h002});
            u_ctrl.shift(34'h0, 34, rb);
            case (c)
                2: x = e_pwr;
                3, 4, 5, 6: x = e_setup[c - 3];
                7: x = e_setup[4];
                8: x = e_tst;
                default: x = '0;
            endcase
            cmp(rb, x);
            chk();
        end
        $display("test readback done");
        @(posedge clock);
        #1 rst = 1'b1;
        u_ctrl.shift(34'h0, 4, rb);
        @(posedge clock);
        #1 rst = 1'b0;
        e_pwr = '0;
        e_tst = '0;
        e_setup = '0;
        repeat (2) @(posedge clock);
        chk();
        u_ctrl.shift(34'h0, 34, rb);
        cmp(rb, 32'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule
